/* File: hdl/phrase_pkg.sv */
// Package of constants for the serial phrase command port
package phrase_pkg;
    localparam int          CODE_BITS      = 8;
    localparam logic [7:0]  STOP_CODE      = 8'h00;
    localparam logic [7:0]  LAST_PHRASE    = 8'hF7;
    localparam logic [7:0]  FIRST_TEST     = 8'hF8;
    localparam int          ROM_AW         = 18;
    localparam logic [17:0] TABLE_LAST     = 18'h0_07C7;
    localparam logic [17:0] USER_FIRST     = 18'h0_07C8;
    localparam logic [17:0] USER_LAST      = 18'h2_FFFC;
    localparam logic [17:0] TEST_FIRST     = 18'h2_FFFD;
    localparam logic [17:0] TEST_LAST      = 18'h2_FFFF;
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          START_NS       = 1000;
    localparam int          START_CYC      = (START_NS * (CLK_HZ / 1_000_000)
                                              + 999) / 1000;
    localparam int          PLAY_BITS      = 16;
    typedef enum logic [2:0] {
        OPT_A = 3'b000,
        OPT_B = 3'b001,
        OPT_C = 3'b010,
        OPT_D = 3'b011,
        OPT_E = 3'b100,
        OPT_F = 3'b101
    } mask_option_t;
    typedef enum logic [1:0] {
        REGION_TABLE = 2'b00,
        REGION_USER  = 2'b01,
        REGION_TEST  = 2'b10,
        REGION_NONE  = 2'b11
    } rom_region_t;
endpackage : phrase_pkg

/* File: hdl/rom_region_if.sv */
// Interface carrying a ROM address and its decoded region
`timescale 1ns/1ps
interface rom_region_if;
    logic [phrase_pkg::ROM_AW-1:0] addr;
    phrase_pkg::rom_region_t       region;
    logic                          fetch_ok;
    modport decoder (input addr, output region, output fetch_ok);
    modport user    (output addr, input region, input fetch_ok);
endinterface : rom_region_if

/* File: hdl/rom_region_decode.sv */
// ROM address region decoder
`timescale 1ns/1ps
module rom_region_decode (
    rom_region_if.decoder bus
);
    wire in_table = bus.addr <= phrase_pkg::TABLE_LAST;
    wire in_user  = bus.addr >= phrase_pkg::USER_FIRST &&
                    bus.addr <= phrase_pkg::USER_LAST;
    wire in_test  = bus.addr >= phrase_pkg::TEST_FIRST &&
                    bus.addr <= phrase_pkg::TEST_LAST;
    assign bus.region = in_table ? phrase_pkg::REGION_TABLE :
                        in_user  ? phrase_pkg::REGION_USER  :
                        in_test  ? phrase_pkg::REGION_TEST  :
                                   phrase_pkg::REGION_NONE;
    assign bus.fetch_ok = (in_table || in_user) && !in_test;
endmodule : rom_region_decode

/* File: hdl/phrase_command_serial_port.sv */
// Serial phrase command receiver with playback status
`timescale 1ns/1ps
// Function
// - Only the first eight serial clock pulses form the code.
// - Zero stops playback; 01 through F7 select a phrase.
// - Control table 0 to 7C7, user data 7C8 to 2FFFC.
// - Locations 2FFFD to 2FFFF are reserved and never fetched.
// - Build option picks framing style only; clock frequency is fixed by CLK_HZ.
// - Three-wire: accept only while select low; two-wire: tied low.
// - Latch-empty high when a new code can be taken, after reset.
// - Busy low while output is active, high after reset.
// - Reset low gives standby and clears internal state.
module phrase_command_serial_port #(
    parameter phrase_pkg::mask_option_t OPTION   = phrase_pkg::OPT_A,
    parameter int                       PLAY_LEN = 1 << phrase_pkg::PLAY_BITS
) (
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rst_n_in,
    // Serial link
    input  wire logic                          serial_clk_in,
    input  wire logic                          serial_data_in,
    input  wire logic                          chip_select_n_in,
    // Playback side
    input  wire logic                          latch_taken_in,
    input  wire logic                          playback_done_in,
    // Status and command
    output logic                               phrase_latch_empty_out,
    output logic                               busy_n_out,
    output logic [phrase_pkg::CODE_BITS-1:0]   phrase_code_out,
    output logic                               code_valid_out,
    output logic                               stop_out,
    output logic                               test_code_out,
    output logic [phrase_pkg::ROM_AW-1:0]      rom_addr_out,
    output logic                               rom_fetch_ok_out,
    output logic                               three_wire_out
);
    localparam int CW = phrase_pkg::CODE_BITS;

    // =========================================================
    // Option decode
    wire three_wire = OPTION == phrase_pkg::OPT_A ||
                      OPTION == phrase_pkg::OPT_B ||
                      OPTION == phrase_pkg::OPT_C;

    // =========================================================
    // Input synchronisers
    logic [1:0] sck_s, sda_s, sel_s;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sck_s <= 2'h0;
            sda_s <= 2'h3;
            sel_s <= 2'h3;
        end else begin
            sck_s <= {sck_s[0], serial_clk_in};
            sda_s <= {sda_s[0], serial_data_in};
            sel_s <= {sel_s[0], chip_select_n_in};
        end
    end
    logic sck_d, sel_d;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sck_d <= 1'b0;
            sel_d <= 1'b1;
        end else begin
            sck_d <= sck_s[1];
            sel_d <= sel_s[1];
        end
    end
    wire sck_rise = sck_s[1] && !sck_d;
    wire sck_fall = !sck_s[1] && sck_d;
    wire sel_fall = !sel_s[1] && sel_d;
    wire sel_low  = !sel_s[1];

    // =========================================================
    // Two-wire start bit: data low for START_CYC with clock low
    localparam int SW = $clog2(phrase_pkg::START_CYC + 1);
    localparam logic [SW-1:0] START_N = SW'(phrase_pkg::START_CYC);
    logic [SW-1:0] start_cnt;
    wire start_hold = !sda_s[1] && !sck_s[1];
    wire start_seen = start_hold && start_cnt == START_N - SW'(1);
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !start_hold)
            start_cnt <= '0;
        else if (start_cnt != START_N)
            start_cnt <= start_cnt + SW'(1);
    end

    // =========================================================
    // Shift register
    logic [CW-1:0] shift;
    logic [3:0]    nbits;
    logic          armed;
    wire accept   = three_wire ? sel_low : armed;
    wire restart  = three_wire ? sel_fall : start_seen;
    wire full     = nbits == 4'(CW);
    wire take_bit = accept && sck_rise && !full;
    wire last_bit = accept && sck_fall && full && armed;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            shift <= '0;
            nbits <= '0;
            armed <= 1'b0;
        end else if (restart) begin
            nbits <= '0;
            armed <= 1'b1;
        end else if (take_bit) begin
            shift <= {shift[CW-2:0], sda_s[1]};
            nbits <= nbits + 4'h1;
        end else if (last_bit) begin
            armed <= 1'b0;
        end
    end

    // =========================================================
    // Code decode
    wire is_stop  = shift == phrase_pkg::STOP_CODE;
    wire is_test  = shift >= phrase_pkg::FIRST_TEST;
    wire is_play  = !is_stop && shift <= phrase_pkg::LAST_PHRASE;
    wire got_play = last_bit && is_play && phrase_latch_empty_out;

    // =========================================================
    // ROM pointer: table entry four bytes per code
    rom_region_if rb ();
    rom_region_decode rom_region_decode_i (.bus(rb));
    assign rb.addr = phrase_pkg::ROM_AW'({shift, 2'b00});

    // =========================================================
    // Status and outputs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            phrase_latch_empty_out <= 1'b1;
            busy_n_out             <= 1'b1;
            phrase_code_out        <= '0;
            code_valid_out         <= 1'b0;
            stop_out               <= 1'b0;
            test_code_out          <= 1'b0;
            rom_addr_out           <= '0;
            rom_fetch_ok_out       <= 1'b0;
            three_wire_out         <= 1'b0;
        end else begin
            three_wire_out   <= three_wire;
            code_valid_out   <= got_play;
            stop_out         <= last_bit && is_stop;
            test_code_out    <= last_bit && is_test;
            if (got_play) begin
                phrase_code_out  <= shift;
                rom_addr_out     <= rb.addr;
                rom_fetch_ok_out <= rb.fetch_ok;
                phrase_latch_empty_out <= 1'b0;
            end else if (latch_taken_in || (last_bit && is_stop)) begin
                phrase_latch_empty_out <= 1'b1;
            end
            if (last_bit && is_stop)
                busy_n_out <= 1'b1;
            else if (latch_taken_in && !phrase_latch_empty_out)
                busy_n_out <= 1'b0;
            else if (playback_done_in)
                busy_n_out <= 1'b1;
        end
    end

    // =========================================================
    // Checks
    empty_after_rst_a: assert property (@(posedge clk_in)
        !rst_n_in |=> phrase_latch_empty_out)
        else $error("latch empty not high after reset");
    busy_after_rst_a: assert property (@(posedge clk_in)
        !rst_n_in |=> busy_n_out)
        else $error("busy not high after reset");
    eight_bits_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) full |=> nbits == 4'(CW) || $past(restart))
        else $error("bit count passed eight");
    stop_code_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) stop_out |-> busy_n_out == 1'b1 ##0
        $past(shift) == phrase_pkg::STOP_CODE)
        else $error("stop without zero code");
    no_test_latch_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) code_valid_out |->
        phrase_code_out <= phrase_pkg::LAST_PHRASE &&
        phrase_code_out != phrase_pkg::STOP_CODE)
        else $error("reserved code latched");
    test_region_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) rb.addr >= phrase_pkg::TEST_FIRST |->
        !rb.fetch_ok)
        else $error("test region fetch allowed");
    select_gate_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) three_wire && sel_s[1] |-> !take_bit)
        else $error("bit taken while deselected");
    valid_empty_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) code_valid_out |-> !phrase_latch_empty_out)
        else $error("latch empty with new code");
    surplus_hold_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) full |=> $stable(shift))
        else $error("shift moved after eight bits");
    bit_count_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) take_bit && !restart |=>
        nbits == $past(nbits) + 4'h1)
        else $error("bit count step wrong");
    test_apart_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) test_code_out |->
        !code_valid_out && !stop_out)
        else $error("test code also accepted");
    stop_empty_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) stop_out |-> phrase_latch_empty_out)
        else $error("latch not emptied by stop");
    latch_hold_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) !phrase_latch_empty_out |=>
        $stable(phrase_code_out))
        else $error("full latch overwritten");
    valid_once_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) code_valid_out |=> !code_valid_out)
        else $error("second code while latch full");
    busy_play_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) latch_taken_in && !phrase_latch_empty_out &&
        !(last_bit && is_stop) |=> !busy_n_out)
        else $error("busy not low at playback start");
    busy_done_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) playback_done_in && !latch_taken_in |=>
        busy_n_out)
        else $error("busy held after playback end");
    region_map_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) rb.addr <= phrase_pkg::TABLE_LAST |->
        rb.region == phrase_pkg::REGION_TABLE && rb.fetch_ok)
        else $error("table address misdecoded");
    start_arm_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) !three_wire && start_seen |=>
        armed && nbits == 4'h0)
        else $error("start bit did not arm");
    reset_clear_a: assert property (@(posedge clk_in)
        !rst_n_in |=> nbits == 4'h0 && !armed)
        else $error("reset left frame state");
endmodule : phrase_command_serial_port

/* File: sim/serial_ctrl_model.sv */
// Behavioural controller that shifts phrase codes into the port
`timescale 1ns/1ps
module serial_ctrl_model (
    // Serial link
    output logic serial_clk_out,
    output logic serial_data_out,
    output logic chip_select_n_out
);
    initial begin
        serial_clk_out    = 1'b0;
        serial_data_out   = 1'b1;
        chip_select_n_out = 1'b1;
    end
    // Frame of pulses; cut > 0 deselects after that many pulses
    task automatic send(input logic [7:0] code, input int pulses,
                        input int cut);
        int i;
        chip_select_n_out = 1'b0;
        #1001;
        for (i = 0; i < pulses && (cut == 0 || i < cut); i++) begin
            serial_data_out = code[7 - (i % 8)];
            #62.5 serial_clk_out = 1'b1;
            #62.5 serial_clk_out = 1'b0;
        end
        #1000;
        chip_select_n_out = 1'b1;
        // Released line shows no stale value
        serial_data_out = ~serial_data_out;
    endtask : send
    // Two-wire frame: start bit on data, then pulses
    task automatic send2(input logic [7:0] code, input int pulses);
        int i;
        #1001 serial_data_out = 1'b0;
        #1200;
        for (i = 0; i < pulses; i++) begin
            serial_data_out = code[7 - (i % 8)];
            #62.5 serial_clk_out = 1'b1;
            #62.5 serial_clk_out = 1'b0;
        end
        #1000;
        serial_data_out = 1'b1;
    endtask : send2
endmodule : serial_ctrl_model

/* File: sim/phrase_command_serial_port_tb_top.sv */
// Testbench for the serial phrase command port
`timescale 1ns/1ps
module phrase_command_serial_port_tb_top;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        taken = 1'b0;
    logic        done = 1'b0;
    wire         sclk, sdat, csn;
    logic        empty, busy_n, valid, stop, test, ok, three;
    logic [7:0]  code;
    logic [17:0] addr;
    logic        empty2, three2;
    logic [7:0]  code2;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          n_valid = 0, n_stop = 0, n_test = 0;

    always #5 clk_in = ~clk_in;
    always @(negedge clk_in) begin
        n_valid += (valid === 1'b1);
        n_stop += (stop === 1'b1);
        n_test += (test === 1'b1);
    end

    serial_ctrl_model serial_ctrl_model_i (.serial_clk_out(sclk),
        .serial_data_out(sdat), .chip_select_n_out(csn));
    phrase_command_serial_port #(.OPTION(phrase_pkg::OPT_A), .PLAY_LEN(16))
    phrase_command_serial_port_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .serial_clk_in(sclk),
        .serial_data_in(sdat), .chip_select_n_in(csn),
        .latch_taken_in(taken), .playback_done_in(done),
        .phrase_latch_empty_out(empty), .busy_n_out(busy_n),
        .phrase_code_out(code), .code_valid_out(valid), .stop_out(stop),
        .test_code_out(test), .rom_addr_out(addr),
        .rom_fetch_ok_out(ok), .three_wire_out(three));
    phrase_command_serial_port #(.OPTION(phrase_pkg::OPT_D), .PLAY_LEN(16))
    phrase_command_serial_port_2w_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .serial_clk_in(sclk),
        .serial_data_in(sdat), .chip_select_n_in(1'b0),
        .latch_taken_in(taken), .playback_done_in(done),
        .phrase_latch_empty_out(empty2), .busy_n_out(),
        .phrase_code_out(code2), .code_valid_out(), .stop_out(),
        .test_code_out(), .rom_addr_out(), .rom_fetch_ok_out(),
        .three_wire_out(three2));

    task automatic check(string what, logic [17:0] exp, logic [17:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic give_verdict();
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic xfer(logic [7:0] c, int pulses, int cut);
        @(negedge clk_in);
        serial_ctrl_model_i.send(c, pulses, cut);
        repeat (3) @(negedge clk_in);
    endtask : xfer
    task automatic play(logic start);
        if (start) taken = 1'b1;
        else done = 1'b1;
        @(negedge clk_in);
        taken = 1'b0;
        done = 1'b0;
        @(negedge clk_in);
    endtask : play

    task automatic t_reset();
        check("empty", 1, empty);
        check("busy_n", 1, busy_n);
        check("code", 0, code);
    endtask : t_reset
    task automatic t_phrase();
        check("three", 1, three);
        xfer(8'hA5, 10, 0);
        check("code", 18'h0_00A5, code);
        check("valid", 1, n_valid);
        check("empty", 0, empty);
        check("addr", 18'h0_0294, addr);
        check("ok", 1, ok);
    endtask : t_phrase
    task automatic t_full();
        xfer(8'h3C, 8, 0);
        check("code", 18'h0_00A5, code);
        play(1'b1);
        check("busy_n", 0, busy_n);
        check("empty", 1, empty);
        play(1'b0);
        check("busy_n", 1, busy_n);
    endtask : t_full
    task automatic t_codes();
        xfer(8'hF8, 8, 0);
        xfer(8'hFF, 8, 0);
        check("test", 2, n_test);
        check("valid", 1, n_valid);
        xfer(8'hF7, 8, 0);
        check("code", 18'h0_00F7, code);
        check("addr", 18'h0_03DC, addr);
    endtask : t_codes
    task automatic t_stop_cancel();
        xfer(8'h00, 8, 0);
        check("stop", 1, n_stop);
        check("empty", 1, empty);
        xfer(8'hFF, 8, 4);
        xfer(8'h5A, 8, 0);
        check("code", 18'h0_005A, code);
        check("test", 2, n_test);
    endtask : t_stop_cancel
    task automatic t_rerun();
        rst_n_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check("empty", 1, empty);
        check("code", 0, code);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
    endtask : t_rerun
    task automatic t_two_wire();
        @(negedge clk_in);
        serial_ctrl_model_i.send2(8'hFF, 3);
        serial_ctrl_model_i.send2(8'h3C, 8);
        repeat (3) @(negedge clk_in);
        check("code2", 18'h0_003C, code2);
        check("empty2", 0, empty2);
        check("three2", 0, three2);
        check("code", 0, code);
    endtask : t_two_wire

    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (20) @(negedge clk_in);
        t_reset();
        rst_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
        t_phrase();
        t_full();
        t_codes();
        t_stop_cancel();
        t_rerun();
        t_two_wire();
        give_verdict();
    end
endmodule : phrase_command_serial_port_tb_top
